// ### hw/pmrs_defines.svh
// Offsets, field positions, reset values and timing counts of the power mode and reset sequencer
`ifndef PMRS_DEFINES_SVH
`define PMRS_DEFINES_SVH

// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define PMRS_OFF_MODE      8'h00
`define PMRS_OFF_CLKSEL    8'h04
`define PMRS_OFF_DIV       8'h08
`define PMRS_OFF_GATE      8'h0C
`define PMRS_OFF_PDIV      8'h10
`define PMRS_OFF_STATUS    8'h14

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define PMRS_CS_SRC        1:0
`define PMRS_CS_PLL_EN     2
`define PMRS_CS_PLL_CON    3
`define PMRS_CS_MAIN_EN    4
`define PMRS_DIV_CPU       7:0
`define PMRS_DIV_USB       15:8

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define PMRS_CLKSEL_RST    5'h00
`define PMRS_DIV_RST       16'h0000
`define PMRS_RESET_VECTOR  32'h00000000
`define PMRS_RESP_OKAY     2'h0
`define PMRS_RESP_SLVERR   2'h2

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define PMRS_CLK_MHZ        25
`define PMRS_T_RC_START_NS  60000
`define PMRS_T_FLASH_NS     100000
`define PMRS_RC_START_CYC   ((`PMRS_T_RC_START_NS * `PMRS_CLK_MHZ + 999) / 1000)
`define PMRS_FLASH_CYC      ((`PMRS_T_FLASH_NS * `PMRS_CLK_MHZ + 999) / 1000)
`define PMRS_WAKE_RC_CYC    4
`define PMRS_WAKE_MAIN_CYC  4096
`define PMRS_RST_HOLD_CYC   8

`endif

// ### hw/pmrs_pkg.sv
// Types shared by the power mode and reset sequencer
package pmrs_pkg;

   typedef enum logic [1:0] {PMRS_SRC_INT_RC, PMRS_SRC_MAIN, PMRS_SRC_PLL, PMRS_SRC_RTC} pmrs_src_type;
   typedef enum logic [1:0] {PMRS_MODE_RUN, PMRS_MODE_IDLE, PMRS_MODE_SLEEP, PMRS_MODE_PDOWN} pmrs_mode_type;
   typedef enum logic [2:0] {ST_RESET, ST_RUN, ST_IDLE, ST_SLEEP, ST_PDOWN, ST_START, ST_WAKE} pmrs_state_type;

   typedef struct packed {
      logic        awvalid;
      logic [7:0]  awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [7:0]  araddr;
      logic        rready;
   } pmrs_axil_req_type;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } pmrs_axil_rsp_type;

endpackage : pmrs_pkg

// ### hw/pmrs_sync.sv
// Two-flop synchroniser for a group of level inputs
`timescale 1ns/10ps
module pmrs_sync #(
   parameter int            W       = 1,
   parameter logic [W-1:0]  RST_VAL = '0
) (
   // Clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_rst_b,
   // Levels
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         meta_r <= RST_VAL;
         o_q    <= RST_VAL;
      end else begin
         meta_r <= i_d;
         o_q    <= meta_r;
      end
   end
endmodule : pmrs_sync

// ### hw/pmrs_top.sv
// Power mode, wake-up timing, reset and brownout sequencer with AXI4-Lite registers
//
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "pmrs_defines.svh"
module pmrs_top #(
   parameter int NPERIPH = 16
) (
   // Clock and power-on reset
   input  wire logic                      i_clk,
   input  wire logic                      i_rst_b,
   // Register bus
   input  wire pmrs_pkg::pmrs_axil_req_type i_axi,
   output      pmrs_pkg::pmrs_axil_rsp_type o_axi,
   // Reset and brownout sources
   input  wire logic                      i_ext_rst_b,
   input  wire logic                      i_wdt_rst,
   input  wire logic                      i_brownout_warn,
   input  wire logic                      i_brownout_rst,
   // Oscillator, flash and interrupt status
   input  wire logic                      i_osc_ok,
   input  wire logic                      i_flash_init_done,
   input  wire logic                      i_irq,
   input  wire logic                      i_wake_irq,
   // Chip reset and processor
   output logic                           o_chip_rst_b,
   output logic [31:0]                    o_boot_vector,
   output logic                           o_cpu_core_clk_en,
   output logic [7:0]                     o_cpu_core_clk_div,
   output logic [7:0]                     o_usb_clk_div,
   output logic                           o_brownout_irq,
   // Oscillators and PLL
   output logic [1:0]                     o_clk_src,
   output logic                           o_main_osc_en,
   output logic                           o_int_rc_osc_en,
   output logic                           o_int_rc_out_en,
   output logic                           o_rtc_osc_en,
   output logic                           o_pll_en,
   output logic                           o_pll_connect,
   // Flash and peripherals
   output logic                           o_flash_pwr_en,
   output logic                           o_flash_access_en,
   output logic [NPERIPH-1:0]             o_periph_clk_en,
   output logic [2*NPERIPH-1:0]           o_periph_clk_div
);
   import pmrs_pkg::*;

   generate
      if (NPERIPH < 1 || NPERIPH > 16) begin : g_bad_nperiph
         $error("NPERIPH must lie between 1 and 16");
      end
   endgenerate

   // ------------------------------------------------------------
   // Input synchronisation
   // ------------------------------------------------------------
   logic [3:0] sync_q;
   pmrs_sync #(.W(4), .RST_VAL(4'h0)) u_sync (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .i_d     ({i_ext_rst_b, i_wdt_rst, i_brownout_warn, i_brownout_rst}),
      .o_q     (sync_q)
   );
   wire ext_ok_s  = sync_q[3];
   wire wdt_s     = sync_q[2];
   wire bo_warn_s = sync_q[1];
   wire bo_rst_s  = sync_q[0];
   wire rst_src   = !ext_ok_s || wdt_s || bo_rst_s;

   // ------------------------------------------------------------
   // Registers and sequencer state
   // ------------------------------------------------------------
   pmrs_state_type      state_r, state_nxt;
   pmrs_mode_type       mode_val_r;
   logic                mode_req_r;
   logic [12:0]         cnt_r, cnt_nxt;
   logic [11:0]         fcnt_r, fcnt_nxt;
   logic [4:0]          clksel_r;
   logic [15:0]         div_r;
   logic [NPERIPH-1:0]  gate_r;
   logic [2*NPERIPH-1:0] pdiv_r;

   // Bus state
   logic        aw_rdy_r, w_rdy_r, bvalid_r, ar_rdy_r, rvalid_r;
   logic [7:0]  awaddr_r;
   logic [31:0] wdata_r, rdata_r;
   logic [3:0]  wstrb_r;
   logic [1:0]  bresp_r, rresp_r;

   wire src_is_rc  = clksel_r[`PMRS_CS_SRC] == PMRS_SRC_INT_RC;
   wire low_power  = state_nxt == ST_SLEEP || state_nxt == ST_PDOWN;
   wire enter_lp   = state_r == ST_RUN && mode_req_r &&
                     (mode_val_r == PMRS_MODE_SLEEP || mode_val_r == PMRS_MODE_PDOWN);
   wire pd_wake    = state_r == ST_PDOWN && i_wake_irq && !rst_src;

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = (cnt_r != 13'h0000) ? cnt_r - 13'h0001 : cnt_r;
      unique case (state_r)
         ST_RESET: begin
            if (cnt_r == 13'h0000 && ext_ok_s && i_osc_ok && i_flash_init_done)
               state_nxt = ST_RUN;
         end
         ST_RUN: begin
            if (mode_req_r) begin
               unique case (mode_val_r)
                  PMRS_MODE_RUN:   state_nxt = ST_RUN;
                  PMRS_MODE_IDLE:  state_nxt = ST_IDLE;
                  PMRS_MODE_SLEEP: state_nxt = ST_SLEEP;
                  PMRS_MODE_PDOWN: state_nxt = ST_PDOWN;
               endcase
            end
         end
         ST_IDLE: begin
            if (i_irq)
               state_nxt = ST_RUN;
         end
         ST_SLEEP: begin
            if (i_wake_irq) begin
               state_nxt = ST_WAKE;
               cnt_nxt   = src_is_rc ? 13'(`PMRS_WAKE_RC_CYC) : 13'(`PMRS_WAKE_MAIN_CYC);
            end
         end
         ST_PDOWN: begin
            if (i_wake_irq) begin
               state_nxt = ST_START;
               cnt_nxt   = 13'(`PMRS_RC_START_CYC);
            end
         end
         ST_START: begin
            if (cnt_r == 13'h0001) begin
               state_nxt = ST_WAKE;
               cnt_nxt   = 13'(`PMRS_WAKE_RC_CYC);
            end
         end
         ST_WAKE: begin
            if (cnt_r == 13'h0001)
               state_nxt = ST_RUN;
         end
      endcase
      if (rst_src) begin
         state_nxt = ST_RESET;
         cnt_nxt   = 13'(`PMRS_RST_HOLD_CYC);
      end
   end

   always_comb begin
      fcnt_nxt = (fcnt_r != 12'h000) ? fcnt_r - 12'h001 : fcnt_r;
      if (pd_wake)
         fcnt_nxt = 12'(`PMRS_FLASH_CYC);
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         state_r <= ST_RESET;
         cnt_r   <= 13'(`PMRS_RST_HOLD_CYC);
         fcnt_r  <= 12'h000;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         fcnt_r  <= fcnt_nxt;
      end
   end

   // ------------------------------------------------------------
   // Register bus decode
   // ------------------------------------------------------------
   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (s[i])
            r[8*i +: 8] = d[8*i +: 8];
      end
      return r;
   endfunction : wmerge

   wire        aw_take  = i_axi.awvalid && aw_rdy_r;
   wire        w_take   = i_axi.wvalid && w_rdy_r;
   wire        ar_take  = i_axi.arvalid && ar_rdy_r;
   wire        wr_do    = !aw_rdy_r && !w_rdy_r && !bvalid_r;
   wire        wr_mode  = wr_do && awaddr_r == `PMRS_OFF_MODE;
   wire        wr_cs    = wr_do && awaddr_r == `PMRS_OFF_CLKSEL;
   wire        wr_div   = wr_do && awaddr_r == `PMRS_OFF_DIV;
   wire        wr_gate  = wr_do && awaddr_r == `PMRS_OFF_GATE;
   wire        wr_pdiv  = wr_do && awaddr_r == `PMRS_OFF_PDIV;
   wire        wr_hit   = wr_mode || wr_cs || wr_div || wr_gate || wr_pdiv || awaddr_r == `PMRS_OFF_STATUS;
   wire [31:0] m_cs     = wmerge(32'(clksel_r), wdata_r, wstrb_r);
   wire [31:0] m_div    = wmerge(32'(div_r), wdata_r, wstrb_r);
   wire [31:0] m_gate   = wmerge(32'(gate_r), wdata_r, wstrb_r);
   wire [31:0] m_pdiv   = wmerge(32'(pdiv_r), wdata_r, wstrb_r);
   wire [31:0] status_w = {26'h0, o_flash_access_en, bo_warn_s, 1'b0, 3'(state_r)};
   wire [7:0]  ra       = i_axi.araddr;
   wire        rd_hit   = ra == `PMRS_OFF_MODE || ra == `PMRS_OFF_CLKSEL || ra == `PMRS_OFF_DIV ||
                          ra == `PMRS_OFF_GATE || ra == `PMRS_OFF_PDIV || ra == `PMRS_OFF_STATUS;
   wire [31:0] rd_word  = (ra == `PMRS_OFF_MODE)   ? 32'(mode_val_r) :
                          (ra == `PMRS_OFF_CLKSEL) ? 32'(clksel_r) :
                          (ra == `PMRS_OFF_DIV)    ? 32'(div_r) :
                          (ra == `PMRS_OFF_GATE)   ? 32'(gate_r) :
                          (ra == `PMRS_OFF_PDIV)   ? 32'(pdiv_r) :
                          (ra == `PMRS_OFF_STATUS) ? status_w : 32'h00000000;

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         aw_rdy_r <= 1'b1;
         w_rdy_r  <= 1'b1;
         ar_rdy_r <= 1'b1;
         bvalid_r <= 1'b0;
         rvalid_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r  <= 32'h00000000;
         wstrb_r  <= 4'h0;
         rdata_r  <= 32'h00000000;
         bresp_r  <= `PMRS_RESP_OKAY;
         rresp_r  <= `PMRS_RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_rdy_r <= 1'b0;
            awaddr_r <= i_axi.awaddr;
         end
         if (w_take) begin
            w_rdy_r <= 1'b0;
            wdata_r <= i_axi.wdata;
            wstrb_r <= i_axi.wstrb;
         end
         if (wr_do) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_hit ? `PMRS_RESP_OKAY : `PMRS_RESP_SLVERR;
         end
         if (bvalid_r && i_axi.bready) begin
            bvalid_r <= 1'b0;
            aw_rdy_r <= 1'b1;
            w_rdy_r  <= 1'b1;
         end
         if (ar_take) begin
            ar_rdy_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r  <= rd_word;
            rresp_r  <= rd_hit ? `PMRS_RESP_OKAY : `PMRS_RESP_SLVERR;
         end
         if (rvalid_r && i_axi.rready) begin
            rvalid_r <= 1'b0;
            ar_rdy_r <= 1'b1;
         end
      end
   end

   assign o_axi = '{awready: aw_rdy_r, wready: w_rdy_r, bvalid: bvalid_r, bresp: bresp_r,
                    arready: ar_rdy_r, rvalid: rvalid_r, rdata: rdata_r, rresp: rresp_r};

   // ------------------------------------------------------------
   // Software registers
   // ------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_rst_b || rst_src) begin
         mode_req_r <= 1'b0;
         mode_val_r <= PMRS_MODE_RUN;
         clksel_r   <= `PMRS_CLKSEL_RST;
         div_r      <= `PMRS_DIV_RST;
         gate_r     <= '1;
         pdiv_r     <= '0;
      end else begin
         mode_req_r <= wr_mode;
         if (wr_mode)
            mode_val_r <= pmrs_mode_type'(wdata_r[1:0]);
         if (wr_cs)
            clksel_r <= m_cs[4:0];
         if (wr_div)
            div_r <= m_div[15:0];
         if (wr_gate)
            gate_r <= m_gate[NPERIPH-1:0];
         if (wr_pdiv)
            pdiv_r <= m_pdiv[2*NPERIPH-1:0];
         if (enter_lp) begin
            clksel_r[`PMRS_CS_PLL_EN]  <= 1'b0;
            clksel_r[`PMRS_CS_PLL_CON] <= 1'b0;
            div_r                      <= `PMRS_DIV_RST;
         end
         if (pd_wake)
            clksel_r[`PMRS_CS_SRC] <= PMRS_SRC_INT_RC;
      end
   end

   // ------------------------------------------------------------
   // Registered outputs
   // ------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         o_chip_rst_b       <= 1'b0;
         o_cpu_core_clk_en  <= 1'b0;
         o_main_osc_en      <= 1'b0;
         o_int_rc_osc_en    <= 1'b1;
         o_int_rc_out_en    <= 1'b1;
         o_flash_pwr_en     <= 1'b1;
         o_flash_access_en  <= 1'b0;
         o_periph_clk_en    <= '0;
      end else begin
         o_chip_rst_b       <= state_nxt != ST_RESET;
         o_cpu_core_clk_en  <= state_nxt == ST_RUN;
         o_main_osc_en      <= clksel_r[`PMRS_CS_MAIN_EN] && !low_power;
         o_int_rc_osc_en    <= state_nxt != ST_PDOWN;
         o_int_rc_out_en    <= !low_power;
         o_flash_pwr_en     <= state_nxt != ST_PDOWN;
         o_flash_access_en  <= fcnt_nxt == 12'h000 && state_nxt != ST_PDOWN && state_nxt != ST_RESET;
         o_periph_clk_en    <= low_power || state_nxt == ST_RESET ? '0 : gate_r;
      end
   end

   always_ff @(posedge i_clk) begin
      o_boot_vector      <= `PMRS_RESET_VECTOR;
      o_rtc_osc_en       <= 1'b1;
      o_brownout_irq     <= i_rst_b && bo_warn_s;
      o_clk_src          <= i_rst_b ? clksel_r[`PMRS_CS_SRC] : PMRS_SRC_INT_RC;
      o_pll_en           <= i_rst_b && clksel_r[`PMRS_CS_PLL_EN];
      o_pll_connect      <= i_rst_b && clksel_r[`PMRS_CS_PLL_CON];
      o_cpu_core_clk_div <= i_rst_b ? div_r[`PMRS_DIV_CPU] : 8'h00;
      o_usb_clk_div      <= i_rst_b ? div_r[`PMRS_DIV_USB] : 8'h00;
      o_periph_clk_div   <= i_rst_b ? pdiv_r : '0;
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   property p_idle_gated;
      @(posedge i_clk) disable iff (!i_rst_b) (state_r == ST_IDLE) |-> !o_cpu_core_clk_en;
   endproperty
   a_idle_gated: assert property (p_idle_gated) else $error("cpu clock running in idle");

   property p_sleep_clocks;
      @(posedge i_clk) disable iff (!i_rst_b)
         (state_r == ST_SLEEP && $past(state_r) == ST_SLEEP) |->
         !o_main_osc_en && !o_int_rc_out_en && o_int_rc_osc_en && o_rtc_osc_en;
   endproperty
   a_sleep_clocks: assert property (p_sleep_clocks) else $error("wrong oscillator state in sleep");

   property p_sleep_pll;
      @(posedge i_clk) disable iff (!i_rst_b)
         (state_r == ST_SLEEP) |-> !clksel_r[`PMRS_CS_PLL_EN] && !clksel_r[`PMRS_CS_PLL_CON] && div_r == 16'h0000;
   endproperty
   a_sleep_pll: assert property (p_sleep_pll) else $error("PLL or dividers not cleared in sleep");

   property p_pdown_off;
      @(posedge i_clk) disable iff (!i_rst_b)
         (state_r == ST_PDOWN) |-> !o_int_rc_osc_en && !o_flash_pwr_en && !o_flash_access_en;
   endproperty
   a_pdown_off: assert property (p_pdown_off) else $error("RC oscillator or flash on in power-down");

   property p_wake_rc;
      @(posedge i_clk) disable iff (!i_rst_b || rst_src)
         (state_r == ST_SLEEP && i_wake_irq && src_is_rc) |=> !o_cpu_core_clk_en [*4] ##1 o_cpu_core_clk_en;
   endproperty
   a_wake_rc: assert property (p_wake_rc) else $error("sleep wake delay not four cycles");

   property p_pdown_src;
      @(posedge i_clk) disable iff (!i_rst_b || rst_src)
         pd_wake |=> clksel_r[`PMRS_CS_SRC] == PMRS_SRC_INT_RC && state_r == ST_START;
   endproperty
   a_pdown_src: assert property (p_pdown_src) else $error("power-down wake did not select RC oscillator");

   property p_flash_block;
      @(posedge i_clk) disable iff (!i_rst_b || rst_src) pd_wake |=> !o_flash_access_en [*8];
   endproperty
   a_flash_block: assert property (p_flash_block) else $error("flash opened before counter expired");

   property p_rst_assert;
      @(posedge i_clk) disable iff (!i_rst_b) rst_src |=> !o_chip_rst_b;
   endproperty
   a_rst_assert: assert property (p_rst_assert) else $error("chip reset not asserted by source");

   property p_rst_release;
      @(posedge i_clk) disable iff (!i_rst_b)
         (o_chip_rst_b && !$past(o_chip_rst_b)) |->
         $past(i_flash_init_done) && $past(i_osc_ok) && $past(ext_ok_s) && $past(cnt_r) == 13'h0000;
   endproperty
   a_rst_release: assert property (p_rst_release) else $error("chip reset released early");

   property p_bo_irq;
      @(posedge i_clk) disable iff (!i_rst_b) bo_warn_s |=> o_brownout_irq;
   endproperty
   a_bo_irq: assert property (p_bo_irq) else $error("brownout interrupt missing");

endmodule : pmrs_top

// ### tb/pmrs_partner.sv
// Oscillator and flash start-up model facing the sequencer
`timescale 1ns/10ps
module pmrs_partner #(
   parameter int OSC_DLY = 20,
   parameter int FLS_DLY = 30
) (
   // Clock
   input  wire logic i_clk,
   // Enables from the sequencer
   input  wire logic i_int_rc_osc_en,
   input  wire logic i_flash_pwr_en,
   // Status back to the sequencer
   output logic      o_osc_ok,
   output logic      o_flash_init_done
);
   int osc_cnt = 0;
   int fls_cnt = 0;
   // Oscillator and flash need time after power before they report ready
   always_ff @(posedge i_clk) begin
      osc_cnt <= !i_int_rc_osc_en ? 0 : (osc_cnt < OSC_DLY) ? osc_cnt + 1 : osc_cnt;
      fls_cnt <= !i_flash_pwr_en ? 0 : (fls_cnt < FLS_DLY) ? fls_cnt + 1 : fls_cnt;
   end
   assign o_osc_ok = (osc_cnt == OSC_DLY);
   assign o_flash_init_done = (fls_cnt == FLS_DLY);
endmodule : pmrs_partner

// ### tb/testbench.sv
// Register-level testbench of the power mode and reset sequencer
`timescale 1ns/10ps
`include "pmrs_defines.svh"
module testbench;
   import pmrs_pkg::*;
   logic i_clk = 0, i_rst_b = 0, i_ext_rst_b = 1, i_wdt_rst = 0, i_brownout_warn = 0, i_brownout_rst = 0;
   logic i_irq = 0, i_wake_irq = 0, i_osc_ok, i_flash_init_done, o_chip_rst_b, o_cpu_core_clk_en;
   logic o_brownout_irq, o_main_osc_en, o_int_rc_osc_en, o_int_rc_out_en, o_rtc_osc_en, o_pll_en;
   logic o_pll_connect, o_flash_pwr_en, o_flash_access_en;
   logic [31:0] o_boot_vector, rd;
   logic [7:0] o_cpu_core_clk_div, o_usb_clk_div;
   logic [1:0] o_clk_src, rr, br;
   logic [15:0] o_periph_clk_en;
   logic [31:0] o_periph_clk_div;
   pmrs_axil_req_type i_axi = '0;
   pmrs_axil_rsp_type o_axi;
   int failures = 0, checks_done = 0, n, n2;
   wire [3:0] obs = {o_flash_access_en, o_chip_rst_b, o_cpu_core_clk_en, o_brownout_irq};
   pmrs_top #(.NPERIPH(16)) u_pmrs_top (.i_clk, .i_rst_b, .i_axi, .o_axi, .i_ext_rst_b, .i_wdt_rst,
      .i_brownout_warn, .i_brownout_rst, .i_osc_ok, .i_flash_init_done, .i_irq, .i_wake_irq, .o_chip_rst_b,
      .o_boot_vector, .o_cpu_core_clk_en, .o_cpu_core_clk_div, .o_usb_clk_div, .o_brownout_irq, .o_clk_src,
      .o_main_osc_en, .o_int_rc_osc_en, .o_int_rc_out_en, .o_rtc_osc_en, .o_pll_en, .o_pll_connect,
      .o_flash_pwr_en, .o_flash_access_en, .o_periph_clk_en, .o_periph_clk_div);
   pmrs_partner u_pmrs_partner (.i_clk, .i_int_rc_osc_en(o_int_rc_osc_en), .i_flash_pwr_en(o_flash_pwr_en),
      .o_osc_ok(i_osc_ok), .o_flash_init_done(i_flash_init_done));
   initial forever #20 i_clk = ~i_clk;
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task conclude;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : conclude
   task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task tmo(input int c);
      if (c >= 5000) begin
         failures++;
         conclude();
      end
   endtask : tmo
   task wt(input int c);
      repeat (c) @(posedge i_clk);
   endtask : wt
   task wh(input int b, output int c);
      c = 0;
      while (obs[b] !== 1'b1 && c < 5000) begin
         @(posedge i_clk);
         c++;
      end
      tmo(c);
   endtask : wh
   task wr(input logic [7:0] a, input logic [31:0] d);
      int c;
      c = 0;
      @(posedge i_clk);
      i_axi.awvalid <= 1;
      i_axi.awaddr <= a;
      i_axi.wvalid <= 1;
      i_axi.wdata <= d;
      i_axi.wstrb <= 4'hF;
      i_axi.bready <= 1;
      do begin
         @(posedge i_clk);
         c++;
         if (i_axi.awvalid && o_axi.awready) i_axi.awvalid <= 0;
         if (i_axi.wvalid && o_axi.wready) i_axi.wvalid <= 0;
      end while (o_axi.bvalid !== 1'b1 && c < 5000);
      br = o_axi.bresp;
      i_axi.bready <= 0;
      tmo(c);
   endtask : wr
   task rg(input logic [7:0] a);
      int c;
      c = 0;
      @(posedge i_clk);
      i_axi.arvalid <= 1;
      i_axi.araddr <= a;
      i_axi.rready <= 1;
      do begin
         @(posedge i_clk);
         c++;
         if (i_axi.arvalid && o_axi.arready) i_axi.arvalid <= 0;
      end while (o_axi.rvalid !== 1'b1 && c < 5000);
      rd = o_axi.rdata;
      rr = o_axi.rresp;
      i_axi.rready <= 0;
      tmo(c);
   endtask : rg
   task slp(input logic [31:0] cs, input int exp);
      wr(`PMRS_OFF_CLKSEL, cs);
      wr(`PMRS_OFF_DIV, 32'h00000302);
      wr(`PMRS_OFF_MODE, 32'h00000002);
      wt(4);
      chk("sleep_clk", {o_main_osc_en, o_int_rc_out_en, o_int_rc_osc_en, o_rtc_osc_en}, 3);
      chk("sleep_pll", {o_pll_en, o_pll_connect, o_cpu_core_clk_div, o_usb_clk_div}, 0);
      chk("sleep_gate", {o_periph_clk_en, o_cpu_core_clk_en}, 0);
      i_irq <= 1;
      wt(10);
      chk("sleep_irq", o_cpu_core_clk_en, 0);
      i_irq <= 0;
      i_wake_irq <= 1;
      wh(1, n);
      chk("sleep_wake", n >= exp && n <= exp + 3, 1);
      i_wake_irq <= 0;
      wr(`PMRS_OFF_DIV, 32'h00000302);
      wt(3);
      chk("div_again", o_usb_clk_div, 8'h03);
   endtask : slp
   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      repeat (5) @(posedge i_clk);
      i_rst_b <= 1;
      chk("rst_low", o_chip_rst_b, 0);
      wh(2, n);
      chk("rst_hold", n >= 10, 1);
      chk("src_boot", {o_clk_src, o_boot_vector}, 0);
      rg(`PMRS_OFF_GATE);
      chk("gate_rst", rd, 32'h0000FFFF);
      rg(8'h20);
      chk("unmapped", rr, `PMRS_RESP_SLVERR);
      wr(8'h20, 32'h00000000);
      chk("wr_unmapped", br, `PMRS_RESP_SLVERR);
      for (int s = 0; s < 3; s++) begin
         i_ext_rst_b <= (s != 0);
         i_wdt_rst <= (s == 1);
         i_brownout_rst <= (s == 2);
         wt(20);
         chk("src_rst", o_chip_rst_b, 0);
         i_ext_rst_b <= 1;
         i_wdt_rst <= 0;
         i_brownout_rst <= 0;
         wh(2, n);
         chk("src_rel", n >= 8, 1);
      end
      $display("test reset done");
      wr(`PMRS_OFF_GATE, 32'h000000A5);
      wr(`PMRS_OFF_PDIV, 32'h12345678);
      chk("bresp_ok", br, `PMRS_RESP_OKAY);
      wt(3);
      chk("gate", {o_periph_clk_en, o_periph_clk_div}, 48'h00A512345678);
      wr(`PMRS_OFF_MODE, 32'h00000001);
      wt(4);
      chk("idle", {o_cpu_core_clk_en, o_periph_clk_en}, 17'h000A5);
      i_irq <= 1;
      wt(3);
      chk("idle_exit", o_cpu_core_clk_en, 1);
      i_irq <= 0;
      i_brownout_warn <= 1;
      wt(5);
      rg(`PMRS_OFF_STATUS);
      chk("bo_irq", {o_brownout_irq, rd[4]}, 3);
      i_brownout_warn <= 0;
      $display("test run done");
      slp(32'h0000001D, 4096);
      slp(32'h00000000, 4);
      $display("test sleep done");
      wr(`PMRS_OFF_CLKSEL, 32'h00000011);
      wr(`PMRS_OFF_MODE, 32'h00000003);
      wt(4);
      chk("pdown", {o_int_rc_osc_en, o_flash_pwr_en, o_flash_access_en}, 0);
      i_wake_irq <= 1;
      wh(1, n);
      chk("pd_wake", n >= 1504 && n <= 1507, 1);
      chk("pd_src", o_clk_src, 0);
      i_wake_irq <= 0;
      wh(3, n2);
      chk("flash_wake", n + n2 >= 2500 && n + n2 <= 2503, 1);
      $display("test power-down done");
      conclude();
   end
endmodule : testbench
